/* hw/net_controller.sv */
// Network controller end: Avalon-MM registers, command send, response FIFO.
//
// Implementation choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module net_controller #(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  sat_link_if.controller   link,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);
  import sat_link_pkg::*;

  ctl_state_s s_r;
  ctl_state_s s_nxt;
  frame_t     frame;
  frame_t     fifo_head;
  logic       fifo_in_ready;
  logic       fifo_valid;
  logic       acc_rd;
  logic       acc_wr;
  logic       go;
  logic [31:0] stat;

  assign acc_rd = avs_read & ~s_r.waitreq;
  assign acc_wr = avs_write & ~s_r.waitreq;

  // Popping the head while a read is accepted keeps readdata and the pop
  // tied to the same entry, unless an empty FIFO takes a push as readdata is captured.
  stream_fifo #(.WIDTH(`PAYLOAD_BITS), .DEPTH(FIFO_DEPTH)) i_stream_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (s_r.push),
    .in_ready  (fifo_in_ready),
    .in_data   (s_r.sh),
    .out_valid (fifo_valid),
    .out_ready (acc_rd && avs_address == `REG_RESP),
    .out_data  (fifo_head)
  );

  always_comb begin
    s_nxt = s_r;
    frame = {link.ctl_rx, s_r.sh[`PAYLOAD_BITS-1:1]};
    go = 1'b0;
    stat = '0;
    stat[`ST_BUSY] = s_r.st != C_IDLE;
    stat[`ST_TIMEOUT] = s_r.timeout;
    stat[`ST_AVAIL] = fifo_valid;
    stat[`ST_FULL] = ~fifo_in_ready;
    stat[`ST_REFUSED] = s_r.refused;
    s_nxt.push = 1'b0;
    s_nxt.waitreq = ~((avs_read | avs_write) & s_r.waitreq);
    if (avs_read && s_r.waitreq) begin
      case (avs_address)
        `REG_CMD_ADDR: s_nxt.rdata = {26'h0, s_r.cmd_addr};
        `REG_CMD_DATA: s_nxt.rdata = {16'h0, s_r.cmd_data};
        `REG_CONFIG:   s_nxt.rdata = {30'h0, s_r.rate};
        `REG_STATUS:   s_nxt.rdata = stat;
        `REG_RESP:     s_nxt.rdata = fifo_valid ? {10'h0, fifo_head} : '0;
        default:       s_nxt.rdata = '0;
      endcase
    end
    if (acc_wr) begin
      case (avs_address)
        `REG_CMD_ADDR: s_nxt.cmd_addr = avs_writedata[`ADDR_W-1:0]; // [R6]
        `REG_CMD_DATA: s_nxt.cmd_data = avs_writedata[`DATA_W-1:0];
        `REG_CONFIG:   s_nxt.rate = avs_writedata[1:0]; // [R2]
        `REG_GO:       go = 1'b1;
        `REG_STATUS: begin
          if (avs_writedata[`ST_TIMEOUT]) begin
            s_nxt.timeout = 1'b0;
          end
          if (avs_writedata[`ST_REFUSED]) begin
            s_nxt.refused = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // A full FIFO holds off new commands, so every response has room.
    if (go && (s_r.st != C_IDLE || !fifo_in_ready)) begin
      s_nxt.refused = 1'b1;
    end
    unique case (s_r.st)
      C_IDLE: begin
        if (go && fifo_in_ready) begin
          s_nxt.st = C_TX;
          s_nxt.div = rate_div(s_r.rate[1], s_r.rate[0]); // [R1] [R14]
          s_nxt.tick = rate_div(s_r.rate[1], s_r.rate[0]) - 6'h01;
          s_nxt.sh = {s_r.cmd_data, s_r.cmd_addr};
          s_nxt.tx_drive_enable = 1'b1;
          s_nxt.txd = 1'b1;
          s_nxt.nbit = '0;
        end
      end
      C_TX: begin
        if (s_r.tick != '0) begin
          s_nxt.tick = s_r.tick - 6'h01;
        end else if (s_r.nbit == `TX_END_BIT) begin
          s_nxt.tx_drive_enable = 1'b0;
          s_nxt.txd = 1'b0;
          s_nxt.st = C_WAIT;
          s_nxt.tmo = '0;
          s_nxt.tick = s_r.div - 6'h01;
        end else begin
          s_nxt.txd = s_r.sh[0];
          s_nxt.sh = s_r.sh >> 1;
          s_nxt.tick = s_r.div - 6'h01;
          s_nxt.nbit = s_r.nbit + 5'h01;
        end
      end
      C_WAIT: begin
        if (link.ctl_rx) begin
          s_nxt.st = C_START;
          s_nxt.tick = s_r.div >> 1;
        end else if (s_r.tick != '0) begin
          s_nxt.tick = s_r.tick - 6'h01;
        end else if (s_r.tmo == `RESP_TMO_LAST) begin
          // A silent node looks like this too.
          s_nxt.timeout = 1'b1; // [R7] [R13]
          s_nxt.st = C_IDLE;
        end else begin
          s_nxt.tmo = s_r.tmo + 7'h01;
          s_nxt.tick = s_r.div - 6'h01;
        end
      end
      C_START: begin
        if (s_r.tick != '0) begin
          s_nxt.tick = s_r.tick - 6'h01;
        end else if (link.ctl_rx) begin
          s_nxt.st = C_BITS;
          s_nxt.tick = s_r.div - 6'h01;
          s_nxt.nbit = '0;
        end else begin
          s_nxt.st = C_WAIT;
        end
      end
      C_BITS: begin
        if (s_r.tick != '0) begin
          s_nxt.tick = s_r.tick - 6'h01;
        end else begin
          s_nxt.sh = frame;
          s_nxt.tick = s_r.div - 6'h01;
          s_nxt.nbit = s_r.nbit + 5'h01;
          if (s_r.nbit == `RX_LAST_BIT) begin
            s_nxt.push = 1'b1;
            s_nxt.st = C_GAP;
          end
        end
      end
      C_GAP: begin
        if (s_r.tick != '0) begin
          s_nxt.tick = s_r.tick - 6'h01;
        end else begin
          s_nxt.st = C_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
      s_r.rate <= `RATE_RESET;
      s_r.waitreq <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.cmd_line    = s_r.txd;
  assign link.cmd_en      = s_r.tx_drive_enable;
  assign avs_readdata    = s_r.rdata;
  assign avs_waitrequest = s_r.waitreq;
endmodule

/* hw/sat_link_consts.svh */
// Constants shared by the satellite node and the network controller.
`ifndef SAT_LINK_CONSTS_SVH
`define SAT_LINK_CONSTS_SVH
`define ADDR_W          6
`define DATA_W          16
`define PAYLOAD_BITS    22
`define RX_LAST_BIT     5'h15
`define TX_END_BIT      5'h16
`define DIV_RATE_HH     6'h04
`define DIV_RATE_HL     6'h08
`define DIV_RATE_LH     6'h10
`define DIV_RATE_LL     6'h20
`define STATION_NONE    6'h00
`define RATE_RESET      2'h3
`define RESP_TMO_LAST   7'h3F
`define REG_CMD_ADDR    5'h00
`define REG_CMD_DATA    5'h04
`define REG_CONFIG      5'h08
`define REG_GO          5'h0C
`define REG_STATUS      5'h10
`define REG_RESP        5'h14
`define ST_BUSY         0
`define ST_TIMEOUT      1
`define ST_AVAIL        2
`define ST_FULL         3
`define ST_REFUSED      4
`endif

/* hw/sat_link_if.sv */
// Serial link wiring between the network controller and a satellite node.
`timescale 1ns/1ps
interface sat_link_if #(parameter bit HALF_DUPLEX = 1'b0);
  logic cmd_line;
  logic cmd_en;
  logic resp_line;
  logic resp_en;
  logic dev_rx;
  logic ctl_rx;
  logic shared;

  // An undriven pair reads low, the same level as an idle transmitter.
  assign shared = (cmd_en & cmd_line) | (resp_en & resp_line);
  assign dev_rx = HALF_DUPLEX ? shared : (cmd_en & cmd_line);
  assign ctl_rx = HALF_DUPLEX ? shared : (resp_en & resp_line);

  modport satellite (input dev_rx, output resp_line, output resp_en);
  modport controller (input ctl_rx, output cmd_line, output cmd_en);
endinterface

/* hw/sat_link_pkg.sv */
// Types and the rate divider shared by both ends of the link.
package sat_link_pkg;
  `include "sat_link_consts.svh"

  typedef logic [`ADDR_W-1:0]       station_t;
  typedef logic [`DATA_W-1:0]       word_t;
  typedef logic [5:0]               tick_t;
  typedef logic [4:0]               bitcnt_t;
  typedef logic [`PAYLOAD_BITS-1:0] frame_t;

  typedef enum logic [2:0] {D_CFG, D_IDLE, D_START, D_BITS, D_GAP, D_TX}
    dev_state_e;
  typedef enum logic [2:0] {C_IDLE, C_TX, C_WAIT, C_START, C_BITS, C_GAP}
    ctl_state_e;

  typedef struct packed {
    dev_state_e st;
    station_t   station;
    tick_t      div;
    tick_t      tick;
    bitcnt_t    nbit;
    frame_t     sh;
    logic       reply;
    logic       tx_drive_enable;
    logic       txd;
    word_t      cmd_word;
    logic       cmd_stb;
  } dev_state_s;

  typedef struct packed {
    ctl_state_e  st;
    logic [1:0]  rate;
    tick_t       div;
    tick_t       tick;
    bitcnt_t     nbit;
    frame_t      sh;
    logic        tx_drive_enable;
    logic        txd;
    station_t    cmd_addr;
    word_t       cmd_data;
    logic [6:0]  tmo;
    logic        waitreq;
    logic [31:0] rdata;
    logic        timeout;
    logic        refused;
    logic        push;
  } ctl_state_s;

  function automatic tick_t rate_div(input logic hi, input logic lo);
    unique case ({hi, lo})
      2'b11: rate_div = `DIV_RATE_HH;
      2'b10: rate_div = `DIV_RATE_HL;
      2'b01: rate_div = `DIV_RATE_LH;
      2'b00: rate_div = `DIV_RATE_LL;
    endcase
  endfunction
endpackage

/* hw/satellite_node.sv */
// Satellite node end: strap decode, reset filter, receiver and responder.
//
// Overview of operation
// R1 - Rate straps pick one of four serial rates.
// R2 - Straps must match the controller's serial rate.
// R3 - Reset low under one clock is ignored; the node clears if a rising clock edge falls inside the low pulse.
// R4 - Hold reset low ten clocks for completeness.
// R5 - Six address straps, high is one, MSB last.
// R6 - Each satellite needs a distinct station address.
// R7 - Address zero never answers, causes no harm.
// R8 - Matching command packet gets an immediate response.
// R9 - Drive enable high exactly during response.
// R10 - Reset forces enable and transmit line low.
// R11 - Receive input ignored while drive enable high.
// R12 - Works on full- and half-duplex wiring.
// R13 - Foreign address: stay silent, enable low.
// R14 - Bit time is clock divided by 4..32.
`timescale 1ns/1ps
module satellite_node (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  sat_link_if.satellite             link,
  input  wire logic                 rate_sel_hi,
  input  wire logic                 rate_sel_lo,
  input  wire sat_link_pkg::station_t station_addr_straps,
  input  wire sat_link_pkg::word_t  resp_word,
  output sat_link_pkg::word_t       cmd_word,
  output logic                      cmd_strobe,
  output sat_link_pkg::station_t    station_address
);
  import sat_link_pkg::*;

  dev_state_s s_r;
  dev_state_s s_nxt;
  frame_t     frame;
  logic       rst_seen_hi_r;
  logic       core_clr_n;

  // The reset pin is sampled every edge; the core clears only once the pin
  // has been seen low at an edge, so a glitch between edges does nothing.
  always_ff @(posedge clk) begin
    rst_seen_hi_r <= reset_n;
  end

  assign core_clr_n = reset_n | rst_seen_hi_r; // [R3] [R4]

  always_comb begin
    s_nxt = s_r;
    frame = {link.dev_rx, s_r.sh[`PAYLOAD_BITS-1:1]};
    s_nxt.cmd_stb = 1'b0;
    unique case (s_r.st)
      D_CFG: begin
        // Straps are taken once after reset; they are meant to be static.
        s_nxt.station = station_addr_straps; // [R5]
        s_nxt.div = rate_div(rate_sel_hi, rate_sel_lo); // [R1] [R14] [R2]
        s_nxt.st = D_IDLE;
      end
      D_IDLE: begin
        // The line is only examined outside transmission, so the echo of
        // our own response on a shared pair is never taken in.
        if (link.dev_rx) begin // [R11] [R12]
          s_nxt.st = D_START;
          s_nxt.tick = s_r.div >> 1;
        end
      end
      D_START: begin
        if (s_r.tick != '0) begin
          s_nxt.tick = s_r.tick - 6'h01;
        end else if (link.dev_rx) begin
          s_nxt.st = D_BITS;
          s_nxt.tick = s_r.div - 6'h01; // [R14]
          s_nxt.nbit = '0;
        end else begin
          s_nxt.st = D_IDLE;
        end
      end
      D_BITS: begin
        if (s_r.tick != '0) begin
          s_nxt.tick = s_r.tick - 6'h01;
        end else begin
          s_nxt.sh = frame;
          s_nxt.tick = s_r.div - 6'h01;
          s_nxt.nbit = s_r.nbit + 5'h01;
          if (s_r.nbit == `RX_LAST_BIT) begin
            // Wait out the last bit before turning the line round.
            s_nxt.st = D_GAP;
            s_nxt.reply = 1'b0; // [R13]
            if (frame[`ADDR_W-1:0] == s_r.station &&
                s_r.station != `STATION_NONE) begin // [R7] [R8]
              s_nxt.reply = 1'b1;
              s_nxt.cmd_word = frame[`PAYLOAD_BITS-1:`ADDR_W];
              s_nxt.cmd_stb = 1'b1;
              s_nxt.sh = {resp_word, s_r.station};
            end
          end
        end
      end
      D_GAP: begin
        if (s_r.tick != '0) begin
          s_nxt.tick = s_r.tick - 6'h01;
        end else if (s_r.reply) begin
          s_nxt.st = D_TX;
          s_nxt.tx_drive_enable = 1'b1; // [R9]
          s_nxt.txd = 1'b1;
          s_nxt.tick = s_r.div - 6'h01;
          s_nxt.nbit = '0;
        end else begin
          s_nxt.st = D_IDLE; // [R13]
        end
      end
      D_TX: begin
        if (s_r.tick != '0) begin
          s_nxt.tick = s_r.tick - 6'h01;
        end else if (s_r.nbit == `TX_END_BIT) begin
          s_nxt.tx_drive_enable = 1'b0; // [R9]
          s_nxt.txd = 1'b0;
          s_nxt.st = D_IDLE;
        end else begin
          s_nxt.txd = s_r.sh[0]; // [R8]
          s_nxt.sh = s_r.sh >> 1;
          s_nxt.tick = s_r.div - 6'h01;
          s_nxt.nbit = s_r.nbit + 5'h01;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge core_clr_n) begin
    if (!core_clr_n) begin
      s_r <= '0; // [R10]
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.resp_line  = s_r.txd;
  assign link.resp_en    = s_r.tx_drive_enable;
  assign cmd_word        = s_r.cmd_word;
  assign cmd_strobe      = s_r.cmd_stb;
  assign station_address = s_r.station;
endmodule

/* hw/stream_fifo.sv */
// Small valid/ready FIFO, depth a power of two.
`timescale 1ns/1ps
module stream_fifo #(
  parameter int WIDTH = 22,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 cnt;
    logic [AW-1:0]               rd;
    logic [AW-1:0]               wr;
  } fifo_s;

  fifo_s s_r;
  fifo_s s_nxt;
  logic  push;
  logic  pop;

  assign in_ready  = s_r.cnt != (AW+1)'(DEPTH);
  assign out_valid = s_r.cnt != '0;
  assign out_data  = s_r.mem[s_r.rd];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wr] = in_data;
      s_nxt.wr = s_r.wr + 1'b1;
    end
    if (pop) begin
      s_nxt.rd = s_r.rd + 1'b1;
    end
    s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

/* verif/satellite_link_frontend_checker.sv */
// Concurrent checks on the serial link between controller and satellite.
`timescale 1ns/1ps
module satellite_link_frontend_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cmd_line,
  input wire logic cmd_en,
  input wire logic resp_line,
  input wire logic resp_en
);
  logic [9:0] len_r;
  logic [9:0] clen_r;
  logic [7:0] gap_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      len_r  <= 10'h000;
      clen_r <= 10'h000;
      gap_r  <= 8'hFF;
    end else begin
      len_r  <= resp_en ? len_r + 10'h001 : 10'h000;
      clen_r <= cmd_en ? clen_r + 10'h001 : 10'h000;
      gap_r  <= cmd_en ? 8'h00 : gap_r + {7'h00, gap_r != 8'hFF};
    end
  end

  // A frame lasts 23 bit times at one of the four dividers.
  function automatic logic legal_len(input logic [9:0] n);
    return n == 10'h05C || n == 10'h0B8 || n == 10'h170 || n == 10'h2E0;
  endfunction

  sequence s_resp_start;
    resp_line [*4];
  endsequence
  sequence s_cmd_start;
    cmd_line [*4];
  endsequence

  chk_resp_len: assert property ($fell(resp_en) |-> legal_len(len_r))
    else $error("response enable length wrong");
  chk_cmd_len: assert property ($fell(cmd_en) |-> legal_len(clen_r))
    else $error("command enable length wrong");
  // Explicit disable overrides the default so reset itself is watched.
  chk_reset_low: assert property (disable iff (1'b0)
    !reset_n ##1 !reset_n |-> !resp_en && !resp_line && !cmd_en)
    else $error("link not quiet in reset");
  chk_answer_soon: assert property ($rose(resp_en) |->
    gap_r != 8'h00 && gap_r <= 8'h40)
    else $error("response not prompt after command");
  chk_one_talker: assert property (resp_en |-> !cmd_en)
    else $error("both ends drive at once");
  chk_idle_low: assert property (!resp_en |-> !resp_line)
    else $error("transmit line high while disabled");
  chk_resp_start: assert property ($rose(resp_en) |-> s_resp_start)
    else $error("response start bit missing");
  chk_cmd_start: assert property ($rose(cmd_en) |-> s_cmd_start)
    else $error("command start bit missing");
endmodule

/* verif/satellite_link_frontend_test.sv */
// Self-checking bench: controller and satellite joined over the link.
`timescale 1ns/1ps
`include "sat_link_consts.svh"
module satellite_link_frontend_test;
  import sat_link_pkg::*;
  logic        clk;
  logic        reset_n;
  logic        rate_hi;
  logic        rate_lo;
  station_t    straps;
  word_t       resp_word;
  word_t       cmd_word;
  logic        cmd_strobe;
  station_t    station_address;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [31:0] rd;
  int          n_errors;
  int          total_checks;
  int          n_strobes = 0;
  logic [31:0] hd_readdata;
  logic [31:0] rd_hd;
  word_t       hd_cmd_word;

  sat_link_if link ();
  satellite_node i_satellite_node (.clk(clk), .reset_n(reset_n),
    .link(link), .rate_sel_hi(rate_hi), .rate_sel_lo(rate_lo),
    .station_addr_straps(straps), .resp_word(resp_word),
    .cmd_word(cmd_word), .cmd_strobe(cmd_strobe),
    .station_address(station_address));
  net_controller i_net_controller (.clk(clk), .reset_n(reset_n),
    .link(link), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  satellite_link_frontend_checker i_satellite_link_frontend_checker (
    .clk(clk), .reset_n(reset_n), .cmd_line(link.cmd_line),
    .cmd_en(link.cmd_en), .resp_line(link.resp_line),
    .resp_en(link.resp_en));

  // A second pair on one shared line must behave cycle for cycle the same.
  sat_link_if #(.HALF_DUPLEX(1'b1)) hd_link ();
  satellite_node i_satellite_node_hd (.clk(clk), .reset_n(reset_n),
    .link(hd_link), .rate_sel_hi(rate_hi), .rate_sel_lo(rate_lo),
    .station_addr_straps(straps), .resp_word(resp_word),
    .cmd_word(hd_cmd_word), .cmd_strobe(), .station_address());
  net_controller i_net_controller_hd (.clk(clk), .reset_n(reset_n),
    .link(hd_link), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(hd_readdata), .avs_waitrequest());

  always @(posedge clk) begin
    if (cmd_strobe === 1'b1) begin
      n_strobes++;
    end
  end

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    @(posedge clk iff avs_waitrequest == 1'b0);
    avs_write <= 1'b0;
  endtask

  task automatic bus_rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read    <= 1'b1;
    @(posedge clk iff avs_waitrequest == 1'b0);
    d = avs_readdata;
    rd_hd = hd_readdata;
    avs_read <= 1'b0;
  endtask

  task automatic do_reset(input logic [1:0] r, input station_t a);
    @(posedge clk);
    reset_n <= 1'b0;
    rate_hi <= r[1];
    rate_lo <= r[0];
    straps  <= a;
    repeat (10) @(posedge clk);
    check_val({link.resp_en, link.resp_line}, 0);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    check_val(station_address, a);
  endtask

  task automatic run_cmd(input station_t a, input word_t d,
                         output logic [31:0] st);
    bus_wr(`REG_CMD_ADDR, {26'h0, a});
    bus_wr(`REG_CMD_DATA, {16'h0, d});
    bus_wr(`REG_GO, 32'h1);
    st = 32'h1;
    for (int i = 0; i < 3000 && st[`ST_BUSY] !== 1'b0; i++) begin
      bus_rd(`REG_STATUS, st);
    end
  endtask

  task automatic test_rates();
    station_t    sa [4] = '{6'h01, 6'h2A, 6'h15, 6'h3F};
    logic [31:0] st;
    word_t       d;
    for (int r = 0; r < 4; r++) begin
      d = {r[1:0], 14'h1234};
      do_reset(r[1:0], sa[r]);
      bus_wr(`REG_CONFIG, r);
      bus_rd(`REG_CONFIG, rd);
      check_val(rd, r);
      resp_word <= ~d;
      run_cmd(sa[r], d, st);
      check_val(st, 32'h4);
      check_val(cmd_word, d);
      check_val(n_strobes, r + 1);
      check_val(hd_cmd_word, d);
      bus_rd(`REG_RESP, rd);
      check_val(rd, {10'h000, ~d, sa[r]});
      check_val(rd_hd, {10'h000, ~d, sa[r]});
    end
  endtask

  task automatic test_silent();
    logic [31:0] st;
    do_reset(2'h3, 6'h15);
    run_cmd(6'h16, 16'hBEEF, st);
    check_val(st, 32'h2);
    bus_rd(`REG_CMD_ADDR, rd);
    check_val(rd, 32'h16);
    bus_rd(`REG_CMD_DATA, rd);
    check_val(rd, 32'hBEEF);
    bus_rd(`REG_RESP, rd);
    check_val(rd, 0);
    bus_wr(`REG_STATUS, 32'h2);
    bus_rd(`REG_STATUS, rd);
    check_val(rd, 0);
    do_reset(2'h3, `STATION_NONE);
    run_cmd(`STATION_NONE, 16'h1234, st);
    check_val(st, 32'h2);
    check_val(cmd_word, 0);
    check_val(n_strobes, 4);
  endtask

  task automatic test_fifo();
    logic [31:0] st;
    do_reset(2'h3, 6'h07);
    for (int k = 0; k < 4; k++) begin
      resp_word <= {12'h0F0, k[3:0]};
      run_cmd(6'h07, 16'h0000, st);
    end
    check_val(st, 32'hC);
    // A command while the buffer is full must be refused, not sent.
    bus_wr(`REG_GO, 32'h1);
    bus_rd(`REG_STATUS, st);
    check_val(st, 32'h1C);
    bus_wr(`REG_STATUS, 32'h10);
    bus_rd(`REG_STATUS, st);
    check_val(st, 32'hC);
    for (int k = 0; k < 5; k++) begin
      bus_rd(`REG_RESP, rd);
      check_val(rd, k < 4 ? {10'h0, 12'h0F0, k[3:0], 6'h07} : 0);
    end
  endtask

  task automatic test_glitch();
    logic [31:0] st;
    @(posedge clk);
    // New straps would only be taken in if the node really reset.
    straps <= 6'h09;
    #5 reset_n = 1'b0;
    #10 reset_n = 1'b1;
    repeat (2) @(posedge clk);
    check_val(station_address, 6'h07);
    resp_word <= 16'h4321;
    run_cmd(6'h07, 16'h00FF, st);
    check_val(st, 32'h4);
    check_val(cmd_word, 16'h00FF);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    reset_n       = 1'b0;
    rate_hi       = 1'b1;
    rate_lo       = 1'b1;
    straps        = 6'h00;
    resp_word     = 16'h0000;
    avs_address   = 5'h00;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0;
    n_errors      = 0;
    total_checks  = 0;
    repeat (3) @(posedge clk);
    test_rates();
    test_silent();
    test_fifo();
    test_glitch();
    give_verdict();
  end

  // Roughly five times the longest expected run.
  initial begin
    #600000;
    n_errors++;
    give_verdict();
  end
endmodule
